// [verilog/dhs_cfg.svh]
`ifndef DHS_CFG_SVH
`define DHS_CFG_SVH
// Functional notes
// - Bus-select strap low at init: I2C slave, SDA open drain only.
// - Seven-bit I2C slave address built partly from two address straps.
// - Address strap tied low gives 0, tied high gives 1.
// - I2C slave works at 100 kbps and 400 kbps.
// - After START, repeated START ignored; wait for STOP.
// - Bus-select strap high at init: 4-wire serial slave instead.
// - 4-wire: read byte shifts out while write byte shifts in.
// - 4-wire: MSB first, active only while slave select low.
// - Serial input sampled on each rising shift clock edge.
// - Serial output changes on falling edges; MSB on select falling.
// - 4-wire serial output is always driven push-pull.
// - Under eight clocks: right-align bits, deliver on select rising.
// - Over eight clocks: keep only last eight bits received.
// - After read LSB, echo received bits MSB first until deselect.
// - Autorun strap high runs at once; low waits for start command.
// - Volume strap high gives unity gain, low gives mute.
// - Periodic open-drain alive pulse while processing runs.
// - Alive period set by command within bounds, fixed default.
// - Audio slave mode: no alive pulses without audio clocks.
// - I2C host transfers are whole 8-bit bytes; 4-wire transfers can be shorter.

// clock and timing
`define DHS_CLK_NS 10
`define DHS_INIT_CYCLES 8
`define DHS_MS_NS 1000000
`define DHS_MS_CYCLES (`DHS_MS_NS / `DHS_CLK_NS)
`define DHS_PULSE_NS 10000
`define DHS_PULSE_CYCLES (`DHS_PULSE_NS / `DHS_CLK_NS)
`define DHS_AUDIO_TIMEOUT_NS 40960
`define DHS_AUDIO_TIMEOUT_CYCLES (`DHS_AUDIO_TIMEOUT_NS / `DHS_CLK_NS)
// alive period in ms
`define DHS_ALIVE_MIN_MS 10'd32
`define DHS_ALIVE_MAX_MS 10'd640
`define DHS_ALIVE_DEF_MS 10'd192
// i2c address: base bits, strap positions
`define DHS_I2C_ADDR_BASE 7'h38
`define DHS_ADDR_BIT1_POS 0
`define DHS_ADDR_BIT2_POS 1
`define DHS_BYTE_BITS 4'h8
`endif

// [verilog/dhs_pkg.sv]
package dhs_pkg;
	typedef enum logic [2:0] {
		I2C_IDLE = 3'b000,
		I2C_ADDR = 3'b001,
		I2C_ADDR_ACK = 3'b010,
		I2C_WRITE = 3'b011,
		I2C_WR_ACK = 3'b100,
		I2C_READ = 3'b101,
		I2C_RD_ACK = 3'b110,
		I2C_WAIT_STOP = 3'b111
	} dhs_i2c_e;
endpackage : dhs_pkg

// [verilog/dhs_sync.sv]
module dhs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] level_q;

	// three-stage chain, first stage feeds only the second
	always_ff @(posedge clock) begin
		if (reset) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change counts once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clock) begin
				if (reset) begin
					level_q[i] <= 1'b0;
				end else if (s2_q[i] == s3_q[i]) begin
					level_q[i] <= s3_q[i];
				end
			end
			assign rise[i] = (s2_q[i] == s3_q[i]) & s3_q[i] & ~level_q[i];
			assign fall[i] = (s2_q[i] == s3_q[i]) & ~s3_q[i] & level_q[i];
		end
	endgenerate

	assign level = level_q;
endmodule : dhs_sync

// [verilog/dhs_host_port.sv]
`include "dhs_cfg.svh"
module dhs_host_port #(
	parameter int MS_CYCLES = `DHS_MS_CYCLES,
	parameter int PULSE_CYCLES = `DHS_PULSE_CYCLES,
	parameter int AUDIO_TIMEOUT = `DHS_AUDIO_TIMEOUT_CYCLES,
	parameter logic [6:0] I2C_ADDR_BASE = `DHS_I2C_ADDR_BASE
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic bus_select_strap,
	input wire logic bit1_or_serial_input,
	input wire logic bit2_or_slave_select_n,
	input wire logic serial_clock,
	input wire logic sda_in,
	output logic sda_serial_output,
	output logic sda_oe_n,
	input wire logic autorun_strap,
	input wire logic silence_at_reset_n,
	input wire logic audio_bit_clock_in,
	input wire logic audio_frame_clock_in,
	input wire logic audio_slave_mode,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	input wire logic [7:0] tx_byte,
	output logic tx_taken,
	input wire logic start_command,
	input wire logic period_cmd_valid,
	input wire logic [9:0] period_cmd_ms,
	output logic init_done,
	output logic four_wire_mode,
	output logic processing_run,
	output logic master_volume_unity,
	output logic alive_pulse_out,
	output logic alive_pulse_oe_n
);
	// ***************************************************
	// pin synchronisers
	// ***************************************************
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] pins;
	logic [NSYNC-1:0] lvl;
	logic [NSYNC-1:0] rise;
	logic [NSYNC-1:0] fall;
	assign pins = {audio_slave_mode, silence_at_reset_n, autorun_strap,
		bus_select_strap, audio_frame_clock_in, audio_bit_clock_in, sda_in,
		bit2_or_slave_select_n, bit1_or_serial_input};

	dhs_sync #(.WIDTH(NSYNC)) u_sync (
		.clock(clock),
		.reset(reset),
		.pin(pins),
		.level(lvl),
		.rise(rise),
		.fall(fall)
	);

	logic scl_q;
	logic scl_prev_q;
	logic scl_s1_q;
	logic scl_s2_q;
	logic scl_s3_q;
	logic scl_rise;
	logic scl_fall;
	// serial clock gets its own chain so both edges are cheap to see
	// oversampling covers both rates
	always_ff @(posedge clock) begin
		if (reset) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			scl_q <= 1'b1;
			scl_prev_q <= 1'b1;
		end else begin
			scl_s1_q <= serial_clock;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			if (scl_s2_q == scl_s3_q) begin
				scl_q <= scl_s3_q;
			end
			scl_prev_q <= scl_q;
		end
	end
	assign scl_rise = scl_q & ~scl_prev_q;
	assign scl_fall = ~scl_q & scl_prev_q;

	// ***************************************************
	// initialization and straps
	// ***************************************************
	logic [3:0] init_cnt_q;
	logic init_done_q;
	logic four_wire_q;
	logic autorun_q;
	logic unity_q;
	logic run_q;
	logic [1:0] addr_strap_q;

	// straps caught once when the init count expires
	always_ff @(posedge clock) begin
		if (reset) begin
			init_cnt_q <= 4'h0;
			init_done_q <= 1'b0;
			four_wire_q <= 1'b0;
			autorun_q <= 1'b0;
			unity_q <= 1'b0;
			addr_strap_q <= 2'h0;
		end else if (!init_done_q) begin
			init_cnt_q <= init_cnt_q + 4'h1;
			if (init_cnt_q == 4'(`DHS_INIT_CYCLES - 1)) begin
				init_done_q <= 1'b1;
				four_wire_q <= lvl[5];
				autorun_q <= lvl[6];
				unity_q <= lvl[7];
				addr_strap_q <= {lvl[1], lvl[0]};
			end
		end
	end

	// run at once or on start command
	always_ff @(posedge clock) begin
		if (reset) begin
			run_q <= 1'b0;
		end else if (init_done_q && (autorun_q || start_command)) begin
			run_q <= 1'b1;
		end
	end

	logic [6:0] my_addr;
	always_comb begin
		my_addr = I2C_ADDR_BASE;
		my_addr[`DHS_ADDR_BIT1_POS] = addr_strap_q[0];
		my_addr[`DHS_ADDR_BIT2_POS] = addr_strap_q[1];
	end

	// ***************************************************
	// i2c slave
	// ***************************************************
	dhs_pkg::dhs_i2c_e st_q;
	logic [7:0] i_sh_q;
	logic [7:0] i_tx_q;
	logic [3:0] i_cnt_q;
	logic i_rw_q;
	logic i_nack_q;
	logic sda_low_q;
	logic i_rx_pulse;
	logic i_tx_pulse;
	logic i_start;
	logic i_stop;
	logic i2c_on;
	assign i2c_on = init_done_q & ~four_wire_q;
	assign i_start = i2c_on & scl_q & fall[2];
	assign i_stop = i2c_on & scl_q & rise[2];

	// i2c byte engine, bits on scl rise, drive on scl fall
	always_ff @(posedge clock) begin
		if (reset || !i2c_on) begin
			st_q <= dhs_pkg::I2C_IDLE;
			i_sh_q <= 8'h00;
			i_tx_q <= 8'h00;
			i_cnt_q <= 4'h0;
			i_rw_q <= 1'b0;
			i_nack_q <= 1'b0;
			sda_low_q <= 1'b0;
		end else if (i_stop) begin
			st_q <= dhs_pkg::I2C_IDLE;
			sda_low_q <= 1'b0;
		end else if (i_start && st_q == dhs_pkg::I2C_IDLE) begin
			st_q <= dhs_pkg::I2C_ADDR;
			i_cnt_q <= 4'h0;
		end else begin
			case (st_q)
				dhs_pkg::I2C_ADDR,
				dhs_pkg::I2C_WRITE: begin
					if (scl_rise) begin
						i_sh_q <= {i_sh_q[6:0], lvl[2]};
						i_cnt_q <= i_cnt_q + 4'h1;
					end else if (scl_fall && i_cnt_q == `DHS_BYTE_BITS) begin
						i_cnt_q <= 4'h0;
						if (st_q == dhs_pkg::I2C_WRITE) begin
							sda_low_q <= 1'b1;
							st_q <= dhs_pkg::I2C_WR_ACK;
						end else if (i_sh_q[7:1] == my_addr) begin
							i_rw_q <= i_sh_q[0];
							sda_low_q <= 1'b1;
							st_q <= dhs_pkg::I2C_ADDR_ACK;
						end else begin
							st_q <= dhs_pkg::I2C_WAIT_STOP;
						end
					end
				end
				dhs_pkg::I2C_ADDR_ACK: begin
					if (scl_fall) begin
						if (i_rw_q) begin
							i_tx_q <= {tx_byte[6:0], 1'b0};
							sda_low_q <= ~tx_byte[7];
							i_cnt_q <= 4'h1;
							st_q <= dhs_pkg::I2C_READ;
						end else begin
							sda_low_q <= 1'b0;
							st_q <= dhs_pkg::I2C_WRITE;
						end
					end
				end
				dhs_pkg::I2C_WR_ACK: begin
					if (scl_fall) begin
						sda_low_q <= 1'b0;
						st_q <= dhs_pkg::I2C_WRITE;
					end
				end
				dhs_pkg::I2C_READ: begin
					if (scl_fall) begin
						if (i_cnt_q == `DHS_BYTE_BITS) begin
							sda_low_q <= 1'b0;
							st_q <= dhs_pkg::I2C_RD_ACK;
						end else begin
							sda_low_q <= ~i_tx_q[7];
							i_tx_q <= {i_tx_q[6:0], 1'b0};
							i_cnt_q <= i_cnt_q + 4'h1;
						end
					end
				end
				dhs_pkg::I2C_RD_ACK: begin
					if (scl_rise) begin
						i_nack_q <= lvl[2];
					end else if (scl_fall) begin
						if (i_nack_q) begin
							st_q <= dhs_pkg::I2C_WAIT_STOP;
						end else begin
							i_tx_q <= {tx_byte[6:0], 1'b0};
							sda_low_q <= ~tx_byte[7];
							i_cnt_q <= 4'h1;
							st_q <= dhs_pkg::I2C_READ;
						end
					end
				end
				default: begin
					sda_low_q <= 1'b0;
				end
			endcase
		end
	end

	// delivery only on a whole byte
	assign i_rx_pulse = (st_q == dhs_pkg::I2C_WRITE) & scl_fall &
		(i_cnt_q == `DHS_BYTE_BITS) & ~i_stop;
	assign i_tx_pulse = scl_fall & ~i_stop & ((st_q == dhs_pkg::I2C_ADDR_ACK
		& i_rw_q) | (st_q == dhs_pkg::I2C_RD_ACK & ~i_nack_q));

	// ***************************************************
	// 4-wire slave
	// ***************************************************
	logic fw_on;
	logic sel_n;
	logic sel_fall;
	logic sel_rise;
	logic [7:0] f_rx_q;
	logic [7:0] f_out_q;
	logic f_last_q;
	logic f_any_q;
	assign fw_on = init_done_q & four_wire_q;
	assign sel_n = lvl[1];
	assign sel_fall = fw_on & fall[1];
	assign sel_rise = fw_on & rise[1];

	// shifting only while selected, MSB first
	always_ff @(posedge clock) begin
		if (reset) begin
			f_rx_q <= 8'h00;
			f_out_q <= 8'h00;
			f_last_q <= 1'b0;
			f_any_q <= 1'b0;
		end else if (sel_fall) begin
			f_out_q <= tx_byte;
			f_rx_q <= 8'h00;
			f_any_q <= 1'b0;
		end else if (fw_on && !sel_n) begin
			if (scl_rise) begin
				// older bits fall off the top
				f_rx_q <= {f_rx_q[6:0], lvl[0]};
				f_last_q <= lvl[0];
				f_any_q <= 1'b1;
			end else if (scl_fall) begin
				// received bits queue behind read byte
				f_out_q <= {f_out_q[6:0], f_last_q};
			end
		end
	end

	// ***************************************************
	// core side and pin drive
	// ***************************************************
	logic [7:0] rx_q;
	logic rx_v_q;
	// right-aligned byte delivered on select rising
	// each completed i2c write data byte handed to core
	always_ff @(posedge clock) begin
		if (reset) begin
			rx_q <= 8'h00;
			rx_v_q <= 1'b0;
		end else begin
			rx_v_q <= i_rx_pulse | (sel_rise & f_any_q);
			if (i_rx_pulse) begin
				rx_q <= i_sh_q;
			end else if (sel_rise && f_any_q) begin
				rx_q <= f_rx_q;
			end
		end
	end

	logic tx_t_q;
	always_ff @(posedge clock) begin
		if (reset) begin
			tx_t_q <= 1'b0;
		end else begin
			tx_t_q <= i_tx_pulse | sel_fall;
		end
	end

	// push-pull in 4-wire mode, open drain in i2c
	assign sda_serial_output = four_wire_q ? f_out_q[7] : 1'b0;
	assign sda_oe_n = four_wire_q ? ~init_done_q : ~sda_low_q;

	// ***************************************************
	// alive pulse
	// ***************************************************
	logic [9:0] period_q;
	always_ff @(posedge clock) begin
		if (reset) begin
			period_q <= `DHS_ALIVE_DEF_MS;
		end else if (period_cmd_valid) begin
			if (period_cmd_ms < `DHS_ALIVE_MIN_MS) begin
				period_q <= `DHS_ALIVE_MIN_MS;
			end else if (period_cmd_ms > `DHS_ALIVE_MAX_MS) begin
				period_q <= `DHS_ALIVE_MAX_MS;
			end else begin
				period_q <= period_cmd_ms;
			end
		end
	end

	// audio clock presence: timeout per clock
	logic [1:0] audio_seen;
	logic [15:0] aud_cnt_q [2];
	genvar k;
	generate
		for (k = 0; k < 2; k++) begin : g_aud
			always_ff @(posedge clock) begin
				if (reset || rise[3 + k]) begin
					aud_cnt_q[k] <= 16'h0000;
				end else if (aud_cnt_q[k] != 16'(AUDIO_TIMEOUT)) begin
					aud_cnt_q[k] <= aud_cnt_q[k] + 16'h0001;
				end
			end
			assign audio_seen[k] = aud_cnt_q[k] != 16'(AUDIO_TIMEOUT);
		end
	endgenerate

	logic alive_ok;
	// slave mode needs both audio clocks
	assign alive_ok = run_q & (~lvl[8] | (&audio_seen));

	logic [16:0] ms_cnt_q;
	logic [9:0] per_cnt_q;
	logic [15:0] pw_cnt_q;
	always_ff @(posedge clock) begin
		if (reset || !alive_ok) begin
			ms_cnt_q <= 17'h00000;
			per_cnt_q <= 10'h000;
			pw_cnt_q <= 16'h0000;
		end else begin
			if (pw_cnt_q != 16'h0000) begin
				pw_cnt_q <= pw_cnt_q - 16'h0001;
			end
			if (ms_cnt_q == 17'(MS_CYCLES - 1)) begin
				ms_cnt_q <= 17'h00000;
				if (per_cnt_q >= period_q - 10'h001) begin
					per_cnt_q <= 10'h000;
					pw_cnt_q <= 16'(PULSE_CYCLES);
				end else begin
					per_cnt_q <= per_cnt_q + 10'h001;
				end
			end else begin
				ms_cnt_q <= ms_cnt_q + 17'h00001;
			end
		end
	end

	assign alive_pulse_out = 1'b0;
	assign alive_pulse_oe_n = ~(pw_cnt_q != 16'h0000);
	assign rx_byte = rx_q;
	assign rx_valid = rx_v_q;
	assign tx_taken = tx_t_q;
	assign init_done = init_done_q;
	assign four_wire_mode = four_wire_q;
	assign processing_run = run_q;
	assign master_volume_unity = unity_q;

	// ***************************************************
	// assertions
	// ***************************************************
	a_mode_fixed: assert property (@(posedge clock) disable iff (reset)
		init_done_q |=> $stable(four_wire_q))
		else $error("bus mode changed after init");
	a_od_never_high: assert property (@(posedge clock) disable iff (reset)
		(i2c_on && !sda_oe_n) |-> !sda_serial_output)
		else $error("i2c data driven high");
	a_restart_ignored: assert property (@(posedge clock) disable iff (reset)
		(i_start && !i_stop && st_q != dhs_pkg::I2C_IDLE) |=>
		st_q != dhs_pkg::I2C_ADDR || $past(st_q) == dhs_pkg::I2C_ADDR)
		else $error("repeated start accepted");
	a_push_pull: assert property (@(posedge clock) disable iff (reset)
		fw_on |-> !sda_oe_n)
		else $error("serial output not driven");
	a_msb_on_select: assert property (@(posedge clock) disable iff (reset)
		sel_fall |=> sda_serial_output == $past(tx_byte[7]))
		else $error("msb not presented on select");
	a_rx_on_deselect: assert property (@(posedge clock) disable iff (reset)
		(sel_rise && f_any_q && !i_rx_pulse) |=> rx_valid &&
		rx_byte == $past(f_rx_q))
		else $error("byte not delivered on deselect");
	a_sample_rise: assert property (@(posedge clock) disable iff (reset)
		(fw_on && !sel_n && scl_rise && !sel_fall) |=>
		f_rx_q[0] == $past(lvl[0]))
		else $error("input bit not sampled");
	a_run_autorun: assert property (@(posedge clock) disable iff (reset)
		(!run_q && !autorun_q && !start_command) |=> !run_q)
		else $error("started without command");
	a_period_bounds: assert property (@(posedge clock) disable iff (reset)
		period_q >= `DHS_ALIVE_MIN_MS && period_q <= `DHS_ALIVE_MAX_MS)
		else $error("alive period out of range");
	a_no_audio_quiet: assert property (@(posedge clock) disable iff (reset)
		!alive_ok |=> alive_pulse_oe_n)
		else $error("alive pulse without audio clocks");
	a_unity_strap: assert property (@(posedge clock) disable iff (reset)
		(!init_done_q ##1 init_done_q) |-> unity_q == $past(lvl[7]))
		else $error("volume strap not taken");
endmodule : dhs_host_port

// [verif/dhs_host_model.sv]
// ****************************************
// host master model, both bus modes
// ****************************************
module dhs_host_model (
	input wire logic clock,
	input wire logic sda_wire,
	output logic scl,
	output logic ss_n,
	output logic mosi,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 1ns;
	int h = 8;
	// pins idle before the first frame
	initial begin
		scl = 1'h1;
		ss_n = 1'h1;
		mosi = 1'h0;
		sda_low = 1'h0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clock);
	endtask : w
	task automatic spi(input int n, input logic [15:0] o,
		output logic [15:0] r);
		r = 16'h0000;
		ss_n <= 1'h0;
		for (int i = 0; i < n; i++) begin
			w(h);
			scl <= 1'h0;
			mosi <= o[n-1-i];
			w(h);
			scl <= 1'h1;
			r = {r[14:0], sda_wire}; // read bit settled since the fall
		end
		w(h);
		scl <= 1'h0;
		w(h);
		ss_n <= 1'h1;
		mosi <= ~mosi; // released line shows no stale value
	endtask : spi
	// one scl pulse, data set mid low phase
	task automatic bit_io(input logic o, output logic i);
		w(h / 2);
		sda_low <= ~o;
		w(h / 2);
		scl <= 1'h1;
		w(h);
		i = sda_wire;
		scl <= 1'h0;
	endtask : bit_io
	// start, also used as repeated start
	task automatic start();
		w(h / 2);
		sda_low <= 1'h0;
		w(h / 2);
		scl <= 1'h1;
		w(h);
		sda_low <= 1'h1;
		w(h);
		scl <= 1'h0;
	endtask : start
	task automatic stop();
		w(h / 2);
		sda_low <= 1'h1;
		w(h / 2);
		scl <= 1'h1;
		w(h);
		sda_low <= 1'h0;
		w(h);
	endtask : stop
	task automatic put(input logic [7:0] b, output logic k);
		logic x;
		for (int i = 7; i >= 0; i--) bit_io(b[i], x);
		bit_io(1'h1, k);
	endtask : put
	task automatic get(output logic [7:0] b);
		logic x;
		for (int i = 7; i >= 0; i--) bit_io(1'h1, b[i]);
		bit_io(1'h1, x); // host nack ends the read
	endtask : get
endmodule : dhs_host_model

// [verif/dsp_host_serial_control_tb_top.sv]
// ****************************************
// host port bench
// ****************************************
module dsp_host_serial_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LIMIT = 100000;
	logic clock = 1'h0;
	logic reset = 1'h1;
	logic bus_select_strap = 1'h0;
	logic strap1 = 1'h0;
	logic strap2 = 1'h0;
	logic wire_4w = 1'h0;
	logic autorun_strap = 1'h0;
	logic silence_at_reset_n = 1'h0;
	logic audio_on = 1'h1;
	logic audio_slave_mode = 1'h0;
	logic bck = 1'h0;
	logic lrc = 1'h0;
	logic was_hi = 1'h0;
	logic [5:0] acnt = 6'h00;
	logic [7:0] tx_byte = 8'h00;
	logic start_command = 1'h0;
	logic period_cmd_valid = 1'h0;
	logic [9:0] period_cmd_ms = 10'h000;
	logic scl, ss_n, mosi, sda_low, sda_wire, sda_serial_output, sda_oe_n;
	logic rx_valid, tx_taken, init_done, four_wire_mode, processing_run;
	logic master_volume_unity, alive_pulse_out, alive_pulse_oe_n;
	logic [7:0] rx_byte, rx_got;
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int n_rx = 0;
	int n_tx = 0;
	always #5 clock = ~clock;
	// open-drain wire in i2c, push-pull output in 4-wire
	assign sda_wire = sda_low ? 1'h0 :
		(sda_oe_n === 1'h0 ? sda_serial_output : 1'h1);
	dhs_host_port #(
		.MS_CYCLES(100),
		.PULSE_CYCLES(5),
		.AUDIO_TIMEOUT(400)
	) u_dut (
		.clock(clock),
		.reset(reset),
		.bus_select_strap(bus_select_strap),
		.bit1_or_serial_input(wire_4w ? mosi : strap1),
		.bit2_or_slave_select_n(wire_4w ? ss_n : strap2),
		.serial_clock(scl),
		.sda_in(sda_wire),
		.sda_serial_output(sda_serial_output),
		.sda_oe_n(sda_oe_n),
		.autorun_strap(autorun_strap),
		.silence_at_reset_n(silence_at_reset_n),
		.audio_bit_clock_in(bck),
		.audio_frame_clock_in(lrc),
		.audio_slave_mode(audio_slave_mode),
		.rx_byte(rx_byte),
		.rx_valid(rx_valid),
		.tx_byte(tx_byte),
		.tx_taken(tx_taken),
		.start_command(start_command),
		.period_cmd_valid(period_cmd_valid),
		.period_cmd_ms(period_cmd_ms),
		.init_done(init_done),
		.four_wire_mode(four_wire_mode),
		.processing_run(processing_run),
		.master_volume_unity(master_volume_unity),
		.alive_pulse_out(alive_pulse_out),
		.alive_pulse_oe_n(alive_pulse_oe_n)
	);
	dhs_host_model u_host (
		.clock(clock),
		.sda_wire(sda_wire),
		.scl(scl),
		.ss_n(ss_n),
		.mosi(mosi),
		.sda_low(sda_low)
	);
	// audio clocks, pulse capture, hang guard
	always @(posedge clock) begin
		acnt <= acnt + 6'h01;
		bck <= audio_on & acnt[1];
		lrc <= audio_on & acnt[5];
		cyc <= cyc + 1;
		if (rx_valid === 1'h1) begin
			rx_got <= rx_byte;
			n_rx <= n_rx + 1;
		end
		if (tx_taken === 1'h1) n_tx <= n_tx + 1;
		if (cyc == LIMIT) begin
			errors++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chk1(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %b seen %b", nm, e, g);
		end
	endtask : chk1
	// straps as {select, bit1, bit2, autorun, volume}
	task automatic rst(input logic [4:0] s);
		@(posedge clock);
		bus_select_strap <= s[4];
		strap1 <= s[3];
		strap2 <= s[2];
		autorun_strap <= s[1];
		silence_at_reset_n <= s[0];
		wire_4w <= s[4];
		u_host.scl <= ~s[4];
		reset <= 1'h1;
		repeat (2) @(posedge clock);
		reset <= 1'h0;
		for (int i = 0; i < 40 && init_done !== 1'h1; i++) @(posedge clock);
		// run flag follows init by one clock
		@(posedge clock);
		chk1("init_done", 1'h1, init_done);
	endtask : rst
	task automatic spi_case(input int n, input logic [15:0] o,
		input logic [15:0] rd, input logic [7:0] rx);
		logic [15:0] r;
		int k;
		k = n_rx;
		u_host.spi(n, o, r);
		u_host.w(8);
		chk("spi_count", 16'(k + 1), 16'(n_rx));
		chk("spi_rx", {8'h00, rx}, {8'h00, rx_got});
		chk("spi_read", rd, r);
	endtask : spi_case
	task automatic i2c_wr(input logic [6:0] a, input logic [7:0] d,
		input logic nak);
		logic k;
		int c;
		c = n_rx;
		u_host.start();
		u_host.put({a, 1'h0}, k);
		chk1("addr_ack", nak, k);
		u_host.put(d, k);
		chk1("data_ack", nak, k);
		u_host.stop();
		u_host.w(8);
		chk("i2c_count", 16'(c + (nak ? 0 : 1)), 16'(n_rx));
		if (!nak) chk("i2c_rx", {8'h00, d}, {8'h00, rx_got});
	endtask : i2c_wr
	task automatic wait_pulse(input int lim, output int t);
		t = -1;
		for (int i = 0; i < lim && t < 0; i++) begin
			@(posedge clock);
			if (alive_pulse_oe_n === 1'h0 && was_hi) t = cyc;
			was_hi = alive_pulse_oe_n === 1'h1;
		end
	endtask : wait_pulse
	// one-clock period command from the core side
	task automatic set_period(input logic [9:0] ms);
		period_cmd_ms <= ms;
		period_cmd_valid <= 1'h1;
		@(posedge clock);
		period_cmd_valid <= 1'h0;
	endtask : set_period
	// main sequence: 4-wire run, then i2c run with alive pulse
	initial begin
		int k, t1, t2;
		logic ack;
		logic [7:0] b;
		rst(5'h10);
		chk1("four_wire", 1'h1, four_wire_mode);
		chk1("unity", 1'h0, master_volume_unity);
		chk1("running", 1'h0, processing_run);
		bus_select_strap <= 1'h0;
		tx_byte <= 8'hA5;
		spi_case(8, 16'h003C, 16'h00A5, 8'h3C);
		spi_case(5, 16'h0016, 16'h0014, 8'h16);
		spi_case(16, 16'hC35A, 16'hA5C3, 8'h5A);
		chk("taken", 16'h0003, 16'(n_tx));
		chk1("sdo_oe_n", 1'h0, sda_oe_n);
		chk1("mode_kept", 1'h1, four_wire_mode);
		start_command <= 1'h1;
		@(posedge clock);
		start_command <= 1'h0;
		u_host.w(8);
		chk1("started", 1'h1, processing_run);
		rst(5'h0B);
		chk1("four_wire", 1'h0, four_wire_mode);
		chk1("unity", 1'h1, master_volume_unity);
		chk1("running", 1'h1, processing_run);
		i2c_wr(7'h39, 8'h96, 1'h0);
		i2c_wr(7'h38, 8'h11, 1'h1);
		u_host.h = 125;
		i2c_wr(7'h39, 8'h4B, 1'h0);
		u_host.h = 8;
		k = n_tx;
		u_host.start();
		u_host.put(8'h72, ack);
		u_host.put(8'hE1, ack);
		u_host.start();
		u_host.put(8'h73, ack);
		u_host.stop();
		u_host.w(8);
		chk("sr_no_read", 16'(k), 16'(n_tx));
		i2c_wr(7'h39, 8'h3D, 1'h0);
		tx_byte <= 8'hC6;
		k = n_tx;
		u_host.start();
		u_host.put(8'h73, ack);
		chk1("rd_ack", 1'h0, ack);
		u_host.get(b);
		u_host.stop();
		u_host.w(8);
		chk("rd_data", 16'h00C6, {8'h00, b});
		chk("rd_taken", 16'(k + 1), 16'(n_tx));
		wait_pulse(25000, t1);
		for (k = 0; k < 50 && alive_pulse_oe_n === 1'h0; k++) @(posedge clock);
		was_hi = 1'h1;
		chk("pulse_len", 16'h0005, 16'(k));
		chk1("open_drain", 1'h0, alive_pulse_out);
		wait_pulse(25000, t2);
		chk1("period_def", 1'h1, (t2 - t1) inside {[19198:19202]});
		set_period(10'h005);
		wait_pulse(25000, t1);
		wait_pulse(5000, t2);
		chk1("period_min", 1'h1, (t2 - t1) inside {[3198:3202]});
		set_period(10'h028);
		wait_pulse(5000, t1);
		wait_pulse(5000, t2);
		chk1("period_mid", 1'h1, (t2 - t1) inside {[3998:4002]});
		audio_slave_mode <= 1'h1;
		wait_pulse(5000, t1);
		chk1("pulse_clocked", 1'h1, t1 >= 0);
		audio_on <= 1'h0;
		u_host.w(600);
		wait_pulse(8000, t1);
		chk1("pulse_absent", 1'h1, t1 < 0);
		audio_on <= 1'h1;
		wait_pulse(8000, t1);
		chk1("pulse_back", 1'h1, t1 >= 0);
		report_and_stop();
	end
endmodule : dsp_host_serial_control_tb_top
